/* shared/drt_pkg.sv */
// Package: register map, field layout and types of the dual reload timer
package drt_pkg;

    // ========================================================================
    // Bus geometry
    // ========================================================================
    localparam int unsigned DRT_ADDR_W = 16;
    localparam int unsigned DRT_DATA_W = 32;
    localparam int unsigned DRT_NUM_TMR = 2;

    // ========================================================================
    // Register byte addresses
    // ========================================================================
    localparam logic [15:0] DRT_OFF_MODE = 16'h6000;
    localparam logic [15:0] DRT_OFF_RELOAD0 = 16'h6004;
    localparam logic [15:0] DRT_OFF_RELOAD1 = 16'h6008;
    localparam logic [15:0] DRT_OFF_COUNT0 = 16'h600C;
    localparam logic [15:0] DRT_OFF_COUNT1 = 16'h6010;
    localparam logic [15:0] DRT_OFF_IRQ_STS = 16'h6014;
    localparam logic [15:0] DRT_OFF_IRQ_MSK = 16'h6018;
    localparam logic [15:0] DRT_OFF_PORT_FN = 16'h601C;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [31:0] DRT_MODE_RST = 32'h00000000;
    localparam logic [31:0] DRT_RELOAD_RST = 32'h00000000;
    localparam logic [31:0] DRT_COUNT_RST = 32'hFFFFFFFF;
    localparam logic [1:0] DRT_IRQ_STS_RST = 2'h0;
    localparam logic [1:0] DRT_IRQ_MSK_RST = 2'h0;
    localparam logic [1:0] DRT_PORT_FN_RST = 2'h0;

    // ========================================================================
    // Mode register fields: timer n uses bits n*STRIDE + {EN, TGL}
    // ========================================================================
    localparam int unsigned DRT_MODE_STRIDE = 3;
    localparam int unsigned DRT_MODE_EN_BIT = 0;
    localparam int unsigned DRT_MODE_TGL_BIT = 1;

    // ========================================================================
    // Bus response codes
    // ========================================================================
    localparam logic [1:0] DRT_RESP_OKAY = 2'h0;
    localparam logic [1:0] DRT_RESP_SLVERR = 2'h2;

    // ========================================================================
    // Types
    // ========================================================================
    // Decoded per-timer controls
    typedef struct packed {
        logic enable;
        logic toggle;
    } drt_ctrl_t;

    // Write channel sequencing
    typedef enum logic [1:0] {
        DRT_WR_IDLE = 2'b01,
        DRT_WR_RESP = 2'b10
    } drt_wr_state_t;

endpackage

/* design/drt_timer.sv */
// Dual 32-bit reload timer with AXI4-Lite register slave and interrupt
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module drt_timer (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // AXI4-Lite write address
    input wire logic [15:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic [15:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Timer outputs and events
    output logic timer_out_zero_o,
    output logic timer_out_one_o,
    output logic [1:0] timer_evt_o,
    // Port pins carrying the timer special function
    output logic port16_o,
    output logic port17_o,
    // Interrupt
    output logic irq_o
);

    // ========================================================================
    // Helper functions
    // ========================================================================
    // Word hit: byte lane bits of the address are ignored
    function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] off);
        reg_hit = (addr[15:2] == off[15:2]);
    endfunction

    // Any mapped register
    function automatic logic reg_known(input logic [15:0] addr);
        reg_known = reg_hit(addr, drt_pkg::DRT_OFF_MODE) |
                    reg_hit(addr, drt_pkg::DRT_OFF_RELOAD0) |
                    reg_hit(addr, drt_pkg::DRT_OFF_RELOAD1) |
                    reg_hit(addr, drt_pkg::DRT_OFF_COUNT0) |
                    reg_hit(addr, drt_pkg::DRT_OFF_COUNT1) |
                    reg_hit(addr, drt_pkg::DRT_OFF_IRQ_STS) |
                    reg_hit(addr, drt_pkg::DRT_OFF_IRQ_MSK) |
                    reg_hit(addr, drt_pkg::DRT_OFF_PORT_FN);
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        strb_merge = res;
    endfunction

    // ========================================================================
    // Write channel: address and data taken in either order
    // ========================================================================
    drt_pkg::drt_wr_state_t wr_state_q, wr_state_d;
    logic aw_full_q;
    logic w_full_q;
    logic [15:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    wire aw_take = s_axi_awvalid_i & awready_q;
    wire w_take = s_axi_wvalid_i & wready_q;
    wire wr_fire = aw_full_q & w_full_q & (wr_state_q == drt_pkg::DRT_WR_IDLE);
    wire b_done = bvalid_q & s_axi_bready_i;
    wire aw_full_d = wr_fire ? 1'b0 : (aw_full_q | aw_take);
    wire w_full_d = wr_fire ? 1'b0 : (w_full_q | w_take);

    // Next write state
    always_comb begin
        wr_state_d = wr_state_q;
        unique case (wr_state_q)
            drt_pkg::DRT_WR_IDLE: begin
                if (wr_fire) begin
                    wr_state_d = drt_pkg::DRT_WR_RESP;
                end
            end
            drt_pkg::DRT_WR_RESP: begin
                if (b_done) begin
                    wr_state_d = drt_pkg::DRT_WR_IDLE;
                end
            end
            default: begin
                wr_state_d = drt_pkg::DRT_WR_IDLE;
            end
        endcase
    end

    // Holding registers; ready drops while a word is parked
    // A write parked during a response waits there until bready is seen
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_state_q <= drt_pkg::DRT_WR_IDLE;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_addr_q <= 16'h0000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            wr_state_q <= wr_state_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q <= ~w_full_d;
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
            end
        end
    end

    // Response raised the cycle after the write commits
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= drt_pkg::DRT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= reg_known(aw_addr_q) ? drt_pkg::DRT_RESP_OKAY : drt_pkg::DRT_RESP_SLVERR;
        end else if (b_done) begin
            bvalid_q <= 1'b0;
        end
    end

    // Register write selects
    wire wr_mode = wr_fire & reg_hit(aw_addr_q, drt_pkg::DRT_OFF_MODE);
    wire wr_sts = wr_fire & reg_hit(aw_addr_q, drt_pkg::DRT_OFF_IRQ_STS);
    wire wr_msk = wr_fire & reg_hit(aw_addr_q, drt_pkg::DRT_OFF_IRQ_MSK);
    wire wr_pfn = wr_fire & reg_hit(aw_addr_q, drt_pkg::DRT_OFF_PORT_FN);
    wire [1:0] wr_reload;
    wire [1:0] wr_count;
    assign wr_reload[0] = wr_fire & reg_hit(aw_addr_q, drt_pkg::DRT_OFF_RELOAD0);
    assign wr_reload[1] = wr_fire & reg_hit(aw_addr_q, drt_pkg::DRT_OFF_RELOAD1);
    assign wr_count[0] = wr_fire & reg_hit(aw_addr_q, drt_pkg::DRT_OFF_COUNT0);
    assign wr_count[1] = wr_fire & reg_hit(aw_addr_q, drt_pkg::DRT_OFF_COUNT1);

    // ========================================================================
    // Shared control registers
    // ========================================================================
    logic [31:0] mode_q;
    logic [1:0] irq_sts_q;
    logic [1:0] irq_msk_q;
    logic [1:0] port_fn_q;
    wire [1:0] tmo;

    // Write-one-to-clear mask; lane 0 qualifies both bits alike
    wire [1:0] sts_clr = {2{wr_sts & w_strb_q[0]}} & w_data_q[1:0];

    // Set beats clear so a time-out in the clearing cycle is kept
    wire [1:0] irq_sts_d = (irq_sts_q & ~sts_clr) | tmo;

    // Mode, mask and port function storage
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_q <= drt_pkg::DRT_MODE_RST;
            irq_msk_q <= drt_pkg::DRT_IRQ_MSK_RST;
            port_fn_q <= drt_pkg::DRT_PORT_FN_RST;
        end else begin
            if (wr_mode) begin
                mode_q <= strb_merge(mode_q, w_data_q, w_strb_q);
            end
            if (wr_msk & w_strb_q[0]) begin
                irq_msk_q <= w_data_q[1:0];
            end
            if (wr_pfn & w_strb_q[0]) begin
                port_fn_q <= w_data_q[1:0];
            end
        end
    end

    // Sticky status and level interrupt
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_sts_q <= drt_pkg::DRT_IRQ_STS_RST;
            irq_o <= 1'b0;
        end else begin
            irq_sts_q <= irq_sts_d;
            irq_o <= |(irq_sts_d & irq_msk_q);
        end
    end

    // ========================================================================
    // Timers
    // ========================================================================
    logic [31:0] reload_w [2];
    logic [31:0] count_w [2];
    logic [1:0] out_d;

    for (genvar i = 0; i < 2; i++) begin : g_tmr
        drt_pkg::drt_ctrl_t ctrl;
        logic [31:0] reload_q;
        logic [31:0] count_q;
        logic [31:0] count_d;
        logic en_prev_q;
        logic out_q;

        assign ctrl.enable = mode_q[i*drt_pkg::DRT_MODE_STRIDE + drt_pkg::DRT_MODE_EN_BIT];
        assign ctrl.toggle = mode_q[i*drt_pkg::DRT_MODE_STRIDE + drt_pkg::DRT_MODE_TGL_BIT];

        // Start on the enable edge; time-out only once running, at zero
        wire start = ctrl.enable & ~en_prev_q;
        assign tmo[i] = ctrl.enable & en_prev_q & (count_q == 32'h00000000);

        // Software write wins over counting so a poked count takes effect
        // A data value of zero gives a time-out in every cycle
        always_comb begin
            if (wr_count[i]) begin
                count_d = strb_merge(count_q, w_data_q, w_strb_q);
            end else if (start) begin
                count_d = reload_q;
            end else if (tmo[i]) begin
                count_d = reload_q;
            end else if (ctrl.enable) begin
                count_d = count_q - 32'h00000001;
            end else begin
                count_d = count_q;
            end
        end

        // Interval: pulse with the time-out; toggle: invert on it
        assign out_d[i] = ctrl.toggle ? (out_q ^ tmo[i]) : tmo[i];

        // Base value, live count, enable history and output level
        // A data value written while running only shows at the next reload
        always_ff @(posedge sys_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                reload_q <= drt_pkg::DRT_RELOAD_RST;
                count_q <= drt_pkg::DRT_COUNT_RST;
                en_prev_q <= 1'b0;
                out_q <= 1'b0;
            end else begin
                if (wr_reload[i]) begin
                    reload_q <= strb_merge(reload_q, w_data_q, w_strb_q);
                end
                count_q <= count_d;
                en_prev_q <= ctrl.enable;
                out_q <= out_d[i];
            end
        end

        assign reload_w[i] = reload_q;
        assign count_w[i] = count_q;
    end

    // Pin, event and port flops; unselected ports rest low
    // Ports are flopped beside the pins so both change on one edge
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_out_zero_o <= 1'b0;
            timer_out_one_o <= 1'b0;
            timer_evt_o <= 2'b00;
            port16_o <= 1'b0;
            port17_o <= 1'b0;
        end else begin
            timer_out_zero_o <= out_d[0];
            timer_out_one_o <= out_d[1];
            timer_evt_o <= tmo;
            port16_o <= port_fn_q[0] & out_d[0];
            port17_o <= port_fn_q[1] & out_d[1];
        end
    end

    // ========================================================================
    // Read channel
    // ========================================================================
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire ar_take = s_axi_arvalid_i & arready_q;
    wire r_done = rvalid_q & s_axi_rready_i;
    wire [15:0] ra = s_axi_araddr_i;

    // Read mux; unmapped reads return zero
    // Decoded from the live address, so the data flop loads at the taking edge
    wire [31:0] rd_mux =
        reg_hit(ra, drt_pkg::DRT_OFF_MODE) ? mode_q :
        reg_hit(ra, drt_pkg::DRT_OFF_RELOAD0) ? reload_w[0] :
        reg_hit(ra, drt_pkg::DRT_OFF_RELOAD1) ? reload_w[1] :
        reg_hit(ra, drt_pkg::DRT_OFF_COUNT0) ? count_w[0] :
        reg_hit(ra, drt_pkg::DRT_OFF_COUNT1) ? count_w[1] :
        reg_hit(ra, drt_pkg::DRT_OFF_IRQ_STS) ? {30'h00000000, irq_sts_q} :
        reg_hit(ra, drt_pkg::DRT_OFF_IRQ_MSK) ? {30'h00000000, irq_msk_q} :
        reg_hit(ra, drt_pkg::DRT_OFF_PORT_FN) ? {30'h00000000, port_fn_q} :
        32'h00000000;

    // One read in flight; address ready returns after the data is taken
    // A second address waits, which keeps the read path a single flop deep
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= drt_pkg::DRT_RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= reg_known(ra) ? drt_pkg::DRT_RESP_OKAY : drt_pkg::DRT_RESP_SLVERR;
        end else if (r_done) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // Bus outputs straight from flops
    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;

endmodule

`default_nettype wire

/* tb/drt_timer_props.sv */
// Checker: bus handshake and timer event properties of the dual reload timer
`timescale 1ns/1ps
`default_nettype none

module drt_timer_props (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Bus handshake
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Timer side
    input wire logic timer_out_zero_o,
    input wire logic timer_out_one_o,
    input wire logic [1:0] timer_evt_o,
    input wire logic irq_o
);
    // ========================================================================
    // Properties, all in the system clock domain
    // ========================================================================
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    pin_rise0_a: assert property ($rose(timer_out_zero_o) |-> timer_evt_o[0])
        else $error("timer zero pin rose without a time-out");
    pin_rise1_a: assert property ($rose(timer_out_one_o) |-> timer_evt_o[1])
        else $error("timer one pin rose without a time-out");
    wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data not returned");
    b_stands_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
    r_stands_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
        && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o)) else $error("read data dropped");
    ar_refuse_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address accepted while data pending");
    irq_rise_a: assert property ($rose(irq_o) |-> timer_evt_o != 2'h0
        || s_axi_bvalid_o || $past(s_axi_bvalid_o))
        else $error("interrupt rose without cause");
    irq_fall_a: assert property ($fell(irq_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o))
        else $error("interrupt fell without a register write");

    // Main scenarios seen
    cover property ($rose(irq_o));
    cover property (timer_evt_o[1]);
    cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule

bind drt_timer drt_timer_props u_props (.sys_clk_i, .nrst_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .timer_out_zero_o, .timer_out_one_o, .timer_evt_o,
    .irq_o);

`default_nettype wire

/* tb/drt_timer_bench.sv */
// Testbench: register access and timer behaviour of the dual reload timer
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("mismatch %s exp %0h got %0h", nm, e, g); \
        end \
    end

module drt_timer_bench;
    // ========================================================================
    // Stimulus and observed signals
    // ========================================================================
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [31:0] wdata = 32'h0, rdata, d, d2;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, timer_out_zero, timer_out_one, p16, p17, irq;
    logic [1:0] bresp, rresp, evt, r;
    logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0,
        32'h0, 32'h0};
    int num_errors = 0, n_compared = 0, i, hi, lo;

    drt_timer u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .timer_out_zero_o(timer_out_zero), .timer_out_one_o(timer_out_one),
        .timer_evt_o(evt), .port16_o(p16), .port17_o(p17), .irq_o(irq));

    // 10 MHz system clock
    always #50 sys_clk_i = ~sys_clk_i;

    // ========================================================================
    // Bus tasks: ready and answers are looked at mid-cycle, where they are settled
    // ========================================================================
    task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic pa, pw, ta, tw;
        @(posedge sys_clk_i);
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw) begin
            @(negedge sys_clk_i);
            ta = pa & awready;
            tw = pw & wready;
            @(posedge sys_clk_i);
            awvalid <= pa & ~ta;
            wvalid <= pw & ~tw;
            pa = pa & ~ta;
            pw = pw & ~tw;
        end
        do @(negedge sys_clk_i); while (bvalid !== 1'b1);
        @(posedge sys_clk_i);
        bready <= 1'b1;
        @(negedge sys_clk_i);
        rs = bresp;
        @(posedge sys_clk_i);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic t;
        @(posedge sys_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        t = 1'b0;
        while (!t) begin
            @(negedge sys_clk_i);
            t = arready;
            @(posedge sys_clk_i);
            arvalid <= ~t;
        end
        do @(negedge sys_clk_i); while (rvalid !== 1'b1);
        @(posedge sys_clk_i);
        rready <= 1'b1;
        @(negedge sys_clk_i);
        v = rdata;
        rs = rresp;
        @(posedge sys_clk_i);
        rready <= 1'b0;
    endtask

    function automatic logic pin(input bit b);
        return b ? timer_out_one : timer_out_zero;
    endfunction

    // Length of one high and the following low stretch of a timer pin
    task automatic span(input bit b, output int h, output int l);
        h = 0;
        l = 0;
        do @(negedge sys_clk_i); while (pin(b) !== 1'b0);
        do @(negedge sys_clk_i); while (pin(b) !== 1'b1);
        while (pin(b) === 1'b1) begin
            h++;
            @(negedge sys_clk_i);
        end
        while (pin(b) === 1'b0) begin
            l++;
            @(negedge sys_clk_i);
        end
    endtask

    task automatic complete_run;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ========================================================================
    // Test sequence
    // ========================================================================
    initial begin
        repeat (5) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        // Reset values, then one unmapped word past the map
        for (i = 0; i < 9; i++) begin
            rd(16'h6000 + 16'(4 * i), d, r);
            `CHK("reset value", rv[i], d)
            `CHK("read resp", (i == 8) ? drt_pkg::DRT_RESP_SLVERR : 2'h0, r)
        end
        // Read back with both enables clear so nothing counts
        for (i = 0; i < 5; i++) begin
            wr(16'h6000 + 16'(4 * i), 32'hA5A5A5A4, r);
            rd(16'h6000 + 16'(4 * i), d, r);
            `CHK("readback", 32'hA5A5A5A4, d)
        end
        wr(16'h6020, 32'h1, r);
        `CHK("unmapped write", drt_pkg::DRT_RESP_SLVERR, r)
        // Interval mode, reload 4: one-cycle pulse every 5 cycles, repeating
        wr(16'h6000, 32'h0, r);
        wr(16'h6004, 32'h4, r);
        wr(16'h6018, 32'h3, r);
        wr(16'h601C, 32'h3, r);
        wr(16'h6000, 32'h1, r);
        for (i = 0; i < 2; i++) begin
            span(1'b0, hi, lo);
            `CHK("pulse width", 1, hi)
            `CHK("pulse period", 5, hi + lo)
        end
        `CHK("timer event", 2'b01, evt)
        `CHK("irq raised", 1'b1, irq)
        // Halt: the count freezes and is not reloaded
        wr(16'h6000, 32'h0, r);
        rd(16'h600C, d, r);
        repeat (10) @(posedge sys_clk_i);
        rd(16'h600C, d2, r);
        `CHK("held count", d, d2)
        `CHK("count in range", 1'b1, d <= 32'h4)
        // Clear both status bits
        wr(16'h6014, 32'h3, r);
        rd(16'h6014, d, r);
        `CHK("status cleared", 32'h0, d)
        `CHK("irq cleared", 1'b0, irq)
        // Enabling copies the reload value into the live count
        wr(16'h6004, 32'd200, r);
        wr(16'h6000, 32'h1, r);
        rd(16'h600C, d, r);
        `CHK("loaded count", 1'b1, d <= 32'd200 && d >= 32'd185)
        // Masked event: status sets, irq stays low until unmasked
        wr(16'h6000, 32'h0, r);
        wr(16'h6018, 32'h0, r);
        wr(16'h6004, 32'h2, r);
        wr(16'h6000, 32'h1, r);
        repeat (10) @(posedge sys_clk_i);
        `CHK("masked irq", 1'b0, irq)
        rd(16'h6014, d, r);
        `CHK("status set", 32'h1, d & 32'h1)
        wr(16'h6018, 32'h3, r);
        `CHK("unmasked irq", 1'b1, irq)
        // Timer 1 toggle with reload 3 beside timer 0 interval with reload 2
        wr(16'h6008, 32'h3, r);
        wr(16'h6000, 32'h19, r);
        span(1'b1, hi, lo);
        `CHK("toggle high", 4, hi)
        `CHK("toggle low", 4, lo)
        @(negedge sys_clk_i);
        `CHK("port 17", timer_out_one, p17)
        span(1'b0, hi, lo);
        `CHK("timer 0 period", 3, hi + lo)
        `CHK("port 16", timer_out_zero, p16)
        `CHK("timer 0 event", 1'b1, evt[0])
        // Stop both, then clear both sticky bits including the toggle timer's
        wr(16'h6000, 32'h0, r);
        wr(16'h6014, 32'h3, r);
        rd(16'h6014, d, r);
        `CHK("both cleared", 32'h0, d)
        `CHK("irq low", 1'b0, irq)
        complete_run();
    end

    // Watchdog against a hung handshake or a silent timer
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        num_errors++;
        complete_run();
    end
endmodule

`default_nettype wire
